// File: core/ssrm_pkg.sv
// Package of constants and types for the safe stop ramp monitor
package ssrm_pkg;
  localparam int unsigned SSRM_CLK_HZ = 50000000;
  localparam int unsigned SSRM_SPD_W = 16;
  localparam int unsigned SSRM_TIME_W = 32;
  localparam logic [1:0] SSRM_SEL_BRAKE_RAMP = 2'h1;
  localparam logic [1:0] SSRM_SEL_ACCEL = 2'h3;
  localparam logic [1:0] SSRM_SEL_DEFAULT = 2'h1;
  localparam logic [15:0] SSRM_SHUTDOWN_RPM_DEFAULT = 16'h000a;
  localparam logic [15:0] SSRM_SPEED_LIMIT_RPM_DEFAULT = 16'h0014;
  localparam logic [15:0] SSRM_REF_RPM_DEFAULT = 16'h05dc;
  localparam logic [15:0] SSRM_DELAY_MS_DEFAULT = 16'h00fa;
  localparam logic [15:0] SSRM_MON_TIME_MS_DEFAULT = 16'h2710;
  localparam logic [15:0] SSRM_STANDSTILL_RPM_DEFAULT = 16'h0014;
  localparam logic [15:0] SSRM_STANDSTILL_MS_DEFAULT = 16'h0004;
  localparam int unsigned SSRM_MS_TICK_CYCLES = SSRM_CLK_HZ / 1000;
  localparam logic [3:0] SSRM_A_SEL = 4'h0;
  localparam logic [3:0] SSRM_A_SHUTDOWN = 4'h1;
  localparam logic [3:0] SSRM_A_SPEED_LIMIT = 4'h2;
  localparam logic [3:0] SSRM_A_REF_SPEED = 4'h3;
  localparam logic [3:0] SSRM_A_DELAY = 4'h4;
  localparam logic [3:0] SSRM_A_MON_TIME = 4'h5;
  localparam logic [3:0] SSRM_A_RAMP_DOWN = 4'h6;
  localparam logic [3:0] SSRM_A_STILL_SPD = 4'h7;
  localparam logic [3:0] SSRM_A_STILL_TIME = 4'h8;
  localparam logic [3:0] SSRM_A_STATUS = 4'h9;
  localparam int unsigned SSRM_NREG = 9;
  localparam int unsigned SSRM_ST_STOP = 0;
  localparam int unsigned SSRM_ST_SUPV = 1;
  localparam int unsigned SSRM_ST_TORQUE_OFF = 2;
  localparam int unsigned SSRM_ST_FAULT = 3;
  localparam int unsigned SSRM_ST_EXT_EN = 4;
  typedef enum logic [2:0] {
    SSRM_IDLE, SSRM_DELAY, SSRM_SUPERVISE, SSRM_TORQUE_OFF, SSRM_FAULT
  } ssrm_state_t;
endpackage : ssrm_pkg

// File: core/ssrm_cfg_if.sv
// Interface carrying configuration words from the register store
`timescale 1ns/1ps
`default_nettype none
interface ssrm_cfg_if;
  logic [15:0] word [0:8];
  logic [3:0] addr;
  logic [15:0] wdata;
  logic we;
  modport store (input addr, input wdata, input we, output word);
  modport user (output addr, output wdata, output we, input word);
endinterface : ssrm_cfg_if
`default_nettype wire

// File: core/ssrm_cfg_regs.sv
// Configuration register store with registered words
`timescale 1ns/1ps
`default_nettype none
module ssrm_cfg_regs
  import ssrm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  ssrm_cfg_if.store cfg
);
  function automatic logic [15:0] reset_value(input int unsigned idx);
    case (idx)
      0: reset_value = {14'h0000, SSRM_SEL_DEFAULT};
      1: reset_value = SSRM_SHUTDOWN_RPM_DEFAULT;
      2: reset_value = SSRM_SPEED_LIMIT_RPM_DEFAULT;
      3: reset_value = SSRM_REF_RPM_DEFAULT;
      4: reset_value = SSRM_DELAY_MS_DEFAULT;
      5: reset_value = SSRM_MON_TIME_MS_DEFAULT;
      6: reset_value = SSRM_MON_TIME_MS_DEFAULT;
      7: reset_value = SSRM_STANDSTILL_RPM_DEFAULT;
      default: reset_value = SSRM_STANDSTILL_MS_DEFAULT;
    endcase
  endfunction
  for (genvar g = 0; g < SSRM_NREG; g++) begin : g_reg
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        cfg.word[g] <= reset_value(g);
      end else if (cfg.we && cfg.addr == 4'(g)) begin
        cfg.word[g] <= cfg.wdata;
      end
    end
  end
endmodule : ssrm_cfg_regs
`default_nettype wire

// File: core/ssrm_top.sv
// Safe stop ramp monitor: delay, falling-curve supervision, torque off
`timescale 1ns/1ps
`default_nettype none
module ssrm_top
  import ssrm_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = SSRM_MS_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [15:0] o_rdata,
  input wire logic i_extended_enable_bit,
  input wire logic i_stop_select,
  input wire logic [15:0] i_speed_setpoint,
  input wire logic [15:0] i_actual_speed,
  output logic o_stop_active_flag,
  output logic o_supervision_active_flag,
  output logic o_torque_off_function,
  output logic o_safety_fault,
  output logic [15:0] o_quick_stop_ramp
);
  ssrm_cfg_if cfg();
  ssrm_cfg_regs u_regs (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .cfg(cfg)
  );
  assign cfg.addr = i_addr;
  assign cfg.wdata = i_wdata;
  assign cfg.we = i_write && (i_addr < SSRM_A_STATUS);

  wire logic [1:0] function_selection = cfg.word[SSRM_A_SEL][1:0];
  wire logic [15:0] shutdown_speed_setting = cfg.word[SSRM_A_SHUTDOWN];
  wire logic [15:0] speed_limit_threshold = cfg.word[SSRM_A_SPEED_LIMIT];
  wire logic [15:0] reference_speed_setting = cfg.word[SSRM_A_REF_SPEED];
  wire logic [15:0] supervision_delay_setting = cfg.word[SSRM_A_DELAY];
  wire logic [15:0] monitoring_time_setting = cfg.word[SSRM_A_MON_TIME];
  wire logic [15:0] ramp_down_time_setting = cfg.word[SSRM_A_RAMP_DOWN];
  wire logic [15:0] standstill_speed_threshold = cfg.word[SSRM_A_STILL_SPD];
  wire logic [15:0] standstill_monitor_time = cfg.word[SSRM_A_STILL_TIME];

  ssrm_state_t state_r, state_nxt;
  logic [31:0] tick_cnt_r;
  logic ms_tick_r;
  logic [16:0] ms_cnt_r;
  logic [15:0] still_cnt_r;
  logic [31:0] curve_acc_r;
  logic [31:0] ramp_acc_r;
  logic [15:0] curve_r;
  logic [15:0] ramp_r;
  logic stop_sel_d_r;

  // Millisecond enable pulse; all curves step once per millisecond
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b0;
    end else if (tick_cnt_r >= MS_TICK_CYCLES - 1) begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      ms_tick_r <= 1'b0;
    end
  end

  wire logic brake_mode = (function_selection == SSRM_SEL_BRAKE_RAMP);
  wire logic accel_mode = (function_selection == SSRM_SEL_ACCEL);
  wire logic mode_valid = brake_mode || accel_mode;
  wire logic enabled = i_extended_enable_bit && mode_valid;
  wire logic stop_rise = i_stop_select && !stop_sel_d_r;
  wire logic [15:0] shutdown_speed =
    (shutdown_speed_setting == 16'h0) ? speed_limit_threshold : shutdown_speed_setting;
  wire logic at_shutdown = i_actual_speed <= shutdown_speed;
  wire logic standstill = (still_cnt_r >= standstill_monitor_time) &&
                          (i_actual_speed <= standstill_speed_threshold);
  // One tick past the setting, so a part-finished first ms never shortens it
  wire logic delay_done = ms_cnt_r > {1'b0, supervision_delay_setting};
  wire logic over_curve = i_actual_speed > curve_r;
  // Per-ms decrement in 1/65536 rpm: ref speed over monitoring time
  wire logic [31:0] curve_step = (monitoring_time_setting == 16'h0) ?
    32'hffffffff : ({reference_speed_setting, 16'h0} / {16'h0, monitoring_time_setting});
  wire logic [31:0] ramp_step = (ramp_down_time_setting == 16'h0) ?
    32'hffffffff : ({reference_speed_setting, 16'h0} / {16'h0, ramp_down_time_setting});

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSRM_IDLE: begin
        if (enabled && stop_rise) begin
          state_nxt = SSRM_DELAY;
        end
      end
      SSRM_DELAY: begin
        // Early shutdown still cuts torque before supervision begins
        if (at_shutdown || standstill) begin
          state_nxt = SSRM_TORQUE_OFF;
        end else if (delay_done) begin
          state_nxt = SSRM_SUPERVISE;
        end
      end
      SSRM_SUPERVISE: begin
        if (at_shutdown || standstill) begin
          state_nxt = SSRM_TORQUE_OFF;
        end else if (over_curve) begin
          state_nxt = SSRM_FAULT;
        end
      end
      SSRM_TORQUE_OFF: begin
        if (!i_stop_select) begin
          state_nxt = SSRM_IDLE;
        end
      end
      SSRM_FAULT: begin
        // Fault latches until the stop is deselected and enable dropped
        if (!i_stop_select && !i_extended_enable_bit) begin
          state_nxt = SSRM_IDLE;
        end
      end
      default: state_nxt = SSRM_IDLE;
    endcase
    if (!i_extended_enable_bit && state_r != SSRM_FAULT) begin
      state_nxt = SSRM_IDLE;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= SSRM_IDLE;
      stop_sel_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      stop_sel_d_r <= i_stop_select;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ms_cnt_r <= 17'h0;
    end else if (state_r != SSRM_DELAY) begin
      ms_cnt_r <= 17'h0;
    end else if (ms_tick_r && !delay_done) begin
      ms_cnt_r <= ms_cnt_r + 17'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      still_cnt_r <= 16'h0;
    end else if (i_actual_speed > standstill_speed_threshold) begin
      still_cnt_r <= 16'h0;
    end else if (ms_tick_r && still_cnt_r != 16'hffff) begin
      still_cnt_r <= still_cnt_r + 16'h1;
    end
  end

  // Curves held in 16.16 fixed point so slow gradients still advance
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      curve_acc_r <= 32'h0;
      ramp_acc_r <= 32'h0;
    end else if (state_r == SSRM_IDLE && state_nxt == SSRM_DELAY) begin
      curve_acc_r <= {i_speed_setpoint, 16'h0};
      ramp_acc_r <= {i_speed_setpoint, 16'h0};
    end else if (ms_tick_r) begin
      if (state_r == SSRM_DELAY || state_r == SSRM_SUPERVISE) begin
        ramp_acc_r <= (ramp_acc_r > ramp_step) ? ramp_acc_r - ramp_step : 32'h0;
      end
      if (state_r == SSRM_SUPERVISE) begin
        curve_acc_r <= (curve_acc_r > curve_step) ? curve_acc_r - curve_step : 32'h0;
      end
    end
  end

  assign curve_r = curve_acc_r[31:16];
  assign ramp_r = ramp_acc_r[31:16];

  wire logic stopping = state_r == SSRM_DELAY || state_r == SSRM_SUPERVISE;
  wire logic [15:0] status_word = {11'h0, enabled, state_r == SSRM_FAULT,
    state_r == SSRM_TORQUE_OFF || state_r == SSRM_FAULT,
    state_r == SSRM_SUPERVISE, state_r != SSRM_IDLE};
  wire logic [15:0] rd_sel = (i_addr == SSRM_A_STATUS) ? status_word :
    (i_addr < SSRM_A_STATUS) ? cfg.word[i_addr] : 16'h0;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 16'h0;
      o_stop_active_flag <= 1'b0;
      o_supervision_active_flag <= 1'b0;
      o_torque_off_function <= 1'b0;
      o_safety_fault <= 1'b0;
      o_quick_stop_ramp <= 16'h0;
    end else begin
      o_rdata <= i_read ? rd_sel : 16'h0;
      o_stop_active_flag <= state_nxt != SSRM_IDLE;
      o_supervision_active_flag <= state_nxt == SSRM_SUPERVISE;
      o_torque_off_function <= state_nxt == SSRM_TORQUE_OFF ||
                               state_nxt == SSRM_FAULT;
      o_safety_fault <= state_nxt == SSRM_FAULT;
      o_quick_stop_ramp <= stopping ? ramp_r : i_speed_setpoint;
    end
  end
endmodule : ssrm_top
`default_nettype wire

// File: bench/ssrm_assertions.sv
// Checker of stop, supervision, torque-off and fault flags
`timescale 1ns/1ps
`default_nettype none
module ssrm_assertions (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_extended_enable_bit,
  input wire logic i_stop_select,
  input wire logic [15:0] i_actual_speed,
  input wire logic o_stop_active_flag,
  input wire logic o_supervision_active_flag,
  input wire logic o_torque_off_function,
  input wire logic o_safety_fault
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  a_stop_rise: assert property (
    $rose(i_stop_select) && i_extended_enable_bit && !o_stop_active_flag
    |-> ##[1:2] o_stop_active_flag) else $error("stop flag late");
  a_supv_clean: assert property (
    o_supervision_active_flag |-> o_stop_active_flag && !o_torque_off_function)
    else $error("supervision flag stray");
  // Delays under 1 ms are never set, so 8 cycles is safe
  a_delay_first: assert property (
    $rose(o_stop_active_flag) |-> !o_supervision_active_flag [*8])
    else $error("supervision too early");
  a_zero_off: assert property (
    o_supervision_active_flag && i_actual_speed == 16'h0000
    |-> ##[1:2] o_torque_off_function) else $error("no torque off");
  a_fault_off: assert property (
    o_safety_fault |-> o_torque_off_function && o_stop_active_flag)
    else $error("fault without torque off");
  a_fault_held: assert property (
    o_safety_fault && (i_stop_select || i_extended_enable_bit) |=> o_safety_fault)
    else $error("fault dropped");
  a_off_held: assert property (
    o_torque_off_function && i_stop_select && i_extended_enable_bit
    |=> o_torque_off_function) else $error("torque off dropped");
  a_disable_idle: assert property (
    $fell(i_extended_enable_bit) && !o_safety_fault |-> ##[1:2] !o_stop_active_flag)
    else $error("disable ignored");
endmodule // ssrm_assertions
bind ssrm_top ssrm_assertions chk (.i_clock, .i_reset_n, .i_extended_enable_bit,
  .i_stop_select, .i_actual_speed, .o_stop_active_flag, .o_supervision_active_flag,
  .o_torque_off_function, .o_safety_fault);
`default_nettype wire

// File: bench/ssrm_ctrl_model.sv
// Safety controller and motor stand-in at the monitor's far side
`timescale 1ns/1ps
`default_nettype none
module ssrm_ctrl_model (
  input wire logic i_clock,
  input wire logic i_stop_req,
  input wire logic i_en_req,
  input wire logic [15:0] i_speed_req,
  output logic o_stop_select,
  output logic o_enable,
  output logic [15:0] o_actual_speed
);
  // Motor and controller lag one cycle, as a real link would
  always_ff @(posedge i_clock) begin
    o_stop_select <= i_stop_req;
    o_enable <= i_en_req;
    o_actual_speed <= i_speed_req;
  end
endmodule // ssrm_ctrl_model
`default_nettype wire

// File: bench/safe_stop_ramp_monitor_test.sv
// Self-checking bench for the safe stop ramp monitor
`timescale 1ns/1ps
`default_nettype none
module safe_stop_ramp_monitor_test;
  import ssrm_pkg::*;
  logic i_clock, i_reset_n, i_write, i_read, stop_req, en_req;
  logic i_stop_select, i_extended_enable_bit;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, i_speed_setpoint, speed_req, i_actual_speed;
  logic [15:0] o_quick_stop_ramp, sp;
  logic o_stop_active_flag, o_supervision_active_flag, o_torque_off_function, o_safety_fault;
  int n_fail, cmp_count;
  logic [15:0] dflt [0:8];
  ssrm_top #(.MS_TICK_CYCLES(10)) dut (.i_clock, .i_reset_n, .i_addr, .i_wdata, .i_write,
    .i_read, .o_rdata, .i_extended_enable_bit, .i_stop_select, .i_speed_setpoint,
    .i_actual_speed, .o_stop_active_flag, .o_supervision_active_flag,
    .o_torque_off_function, .o_safety_fault, .o_quick_stop_ramp);
  ssrm_ctrl_model ctrl (.i_clock, .i_stop_req(stop_req), .i_en_req(en_req),
    .i_speed_req(speed_req), .o_stop_select(i_stop_select),
    .o_enable(i_extended_enable_bit), .o_actual_speed(i_actual_speed));
  task automatic end_sim;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic flag(input int k);
    logic [3:0] f;
    f = {o_safety_fault, o_torque_off_function, o_supervision_active_flag, o_stop_active_flag};
    return f[k];
  endfunction
  task automatic fl(input int k, input logic v);
    chk(16'(flag(k)), 16'(v));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Bounded wait, so a stuck flag ends as a mismatch, not a hang
  task automatic wt(input int k, input int lim);
    for (int n = 0; n < lim && flag(k) !== 1'b1; n++) cyc(1);
    fl(k, 1'b1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  // Setpoint is lowered after selection: the ramp output must then lie below the captured value
  task automatic go(input logic [15:0] s, input logic [15:0] v);
    @(posedge i_clock);
    i_speed_setpoint <= s;
    speed_req <= v;
    @(posedge i_clock);
    stop_req <= 1'b1;
    #1 chk(o_quick_stop_ramp, s);
    wt(0, 6);
    i_speed_setpoint <= s - 16'h012c;
    cyc(20);
    fl(1, 1'b0);
    wt(1, 30);
    chk(16'(o_quick_stop_ramp < s), 16'h0001);
  endtask
  task automatic stop_end;
    @(posedge i_clock) stop_req <= 1'b0;
    cyc(3);
    fl(0, 1'b0);
  endtask
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    repeat (5000) @(posedge i_clock);
    n_fail++;
    end_sim;
  end
  initial begin
    {i_reset_n, i_write, i_read, stop_req, i_addr, i_wdata, speed_req} = '0;
    en_req = 1'b1;
    i_speed_setpoint = '0;
    n_fail = 0;
    cmp_count = 0;
    dflt = '{16'(SSRM_SEL_DEFAULT), SSRM_SHUTDOWN_RPM_DEFAULT, SSRM_SPEED_LIMIT_RPM_DEFAULT,
      SSRM_REF_RPM_DEFAULT, SSRM_DELAY_MS_DEFAULT, SSRM_MON_TIME_MS_DEFAULT, 16'h2710,
      SSRM_STANDSTILL_RPM_DEFAULT, SSRM_STANDSTILL_MS_DEFAULT};
    void'($urandom(32'h5c27));
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    for (int a = 0; a < 9; a++) rd(4'(a), dflt[a]);
    rd(4'ha, 16'h0000);
    wr(4'h9, 16'h001f);
    rd(4'h9, 16'h0010);
    wr(4'h0, 16'h0002);
    rd(4'h9, 16'h0000);
    wr(4'h0, 16'h0003);
    rd(4'h9, 16'h0010);
    @(posedge i_clock) en_req <= 1'b0;
    cyc(2);
    rd(4'h9, 16'h0000);
    @(posedge i_clock) en_req <= 1'b1;
    wr(4'h4, 16'h0003);
    wr(4'h6, 16'h000a);
    wr(4'h8, 16'h0064);
    go(16'h03e8, 16'h03de);
    cyc(20);
    fl(3, 1'b0);
    @(posedge i_clock) speed_req <= 16'h000b;
    cyc(5);
    fl(2, 1'b0);
    @(posedge i_clock) speed_req <= 16'h000a;
    wt(2, 4);
    rd(4'h9, 16'h0015);
    stop_end;
    wr(4'h0, 16'h0001);
    wr(4'h1, 16'h0000);
    go(16'h0320, 16'h0015);
    cyc(5);
    fl(2, 1'b0);
    @(posedge i_clock) speed_req <= 16'h0000;
    wt(2, 4);
    stop_end;
    wr(4'h1, 16'h0001);
    wr(4'h8, 16'h0002);
    go(16'h0320, 16'h01f4);
    @(posedge i_clock) speed_req <= 16'h000f;
    cyc(10);
    fl(2, 1'b0);
    wt(2, 30);
    stop_end;
    sp = 16'h03e8 + 16'($urandom % 1000);
    wr(4'h5, 16'h0064);
    go(sp, sp - 16'h0064);
    cyc(40);
    fl(3, 1'b0);
    wt(3, 60);
    fl(2, 1'b1);
    // Fault outlives deselection while enable stays high
    @(posedge i_clock) stop_req <= 1'b0;
    cyc(3);
    fl(0, 1'b1);
    fl(3, 1'b1);
    @(posedge i_clock) en_req <= 1'b0;
    cyc(4);
    fl(3, 1'b0);
    fl(0, 1'b0);
    @(posedge i_clock) en_req <= 1'b1;
    go(16'h0320, 16'h0300);
    @(posedge i_clock) en_req <= 1'b0;
    cyc(3);
    fl(0, 1'b0);
    fl(1, 1'b0);
    end_sim;
  end
endmodule // safe_stop_ramp_monitor_test
`default_nettype wire
